// ==== rtl/adc_ctl.sv ====
// converter control: enable/start, auto trigger, prescaler, result regs
// assumes trigger flags and the analog result arrive from other clock
// domains or pins and are synchronised here; irq_taken is same clock
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - clearing converter_on powers down and aborts any running conversion
// - single mode: each write of one to conversion_go starts one conversion, except while one is running
// - free running: conversion_go write starts first, rest follow alone
// - first conversion after enable takes 25 converter clocks, others 13
// - conversion_go reads one while converting; written zero is ignored
// - auto_trigger_on: start on rising edge of the selected trigger
// - done flag sets on every completion; result register updates only when not locked
// - irq raised when done flag, done_irq_enable and global enable are one
// - done flag clears on vector taken or on writing one to it
// - converter clock is system clock divided by 2,2,4,8,...,128
// - after reading low byte, result frozen until high byte read
// - right aligned: bits 9:8 in high byte, 7:0 in low byte
// - left aligned: bits 9:2 in high byte, 1:0 in low byte 7:6
// - unipolar: unsigned 10-bit result, saturated when input negative
// - bipolar: two's complement, 9 magnitude bits plus sign
// - trigger select has no effect while auto_trigger_on is zero
// - switching from a clear source to a set source counts as a rising edge and starts
// - switching to free running code 0 never produces a trigger
// - trigger codes: 0 free run, 1 comparator, 2..7 other flags
// - reference and channel changes apply only after conversion completes
// - left_align_result change alters result presentation immediately
module adc_ctl
	import adc_ctl_pkg::*;
(
	// clock, reset, enable
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clk_en,
	// avalon-mm slave
	input wire logic [adc_ctl_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [1:0] avs_response,
	// processor side
	input wire logic global_irq_enable,
	input wire logic irq_taken,
	output logic done_irq,
	// trigger flags 1..7 from other blocks (bit 0 unused)
	input wire logic [adc_ctl_pkg::N_TRIG-1:0] trig_flags,
	// analog front end
	input wire logic [9:0] sample_value,
	output logic conv_clk,
	output logic conv_power,
	output logic conv_sample,
	output logic [1:0] ref_select,
	output logic [4:0] channel_select,
	output logic bipolar_mode
);
	import adc_ctl_pkg::*;

	conv_state_t state_q;
	logic [7:0] csr_a_q, csr_b_q, cfg_q, cfg_act_q;
	logic [9:0] result_q;
	logic lock_q, first_q, init_done_q;
	logic [6:0] pre_q;
	logic cclk_q, tick;
	logic [4:0] cyc_q;
	logic [9:0] smp_s1_q, smp_s2_q;
	logic [N_TRIG-1:0] trg_s1_q, trg_s2_q;
	logic trig_sel_q, trig_edge;
	logic go_wr, done_set, complete;
	logic [31:0] rd_d;
	logic acc_q;
	logic [1:0] resp_d;
	logic wr_a, wr_b, wr_c, rd_lo, rd_hi;
	logic [ADDR_W-3:0] idx;
	logic [7:0] wb, hi_b, lo_b;
	logic [7:0] div_mask;
	logic acc_start;

	// bus timing: an access is taken on the first edge that sees read or
	// write, which also latches read data and response; waitrequest then
	// drops for one cycle, and the master still holds its request at the
	// second edge, where writes take effect
	assign idx = avs_address[ADDR_W-1:2];
	assign wb = avs_writedata[7:0];
	assign acc_start = (avs_read || avs_write) && !acc_q;

	// write strobes in the answer cycle; a write without byte lane 0
	// or to an unmapped word changes nothing
	always_comb begin
		wr_a = 1'b0;
		wr_b = 1'b0;
		wr_c = 1'b0;
		if (avs_write && acc_q && avs_byteenable[0]) begin
			unique case (idx)
				IDX_CSR_A: wr_a = 1'b1;
				IDX_CSR_B: wr_b = 1'b1;
				IDX_CFG: wr_c = 1'b1;
				default: begin
					wr_a = 1'b0;
				end
			endcase
		end
	end

	// read strobes on the taking edge, the same edge that captures the
	// data, so the lock and the byte handed out belong together
	always_comb begin
		rd_lo = 1'b0;
		rd_hi = 1'b0;
		if (avs_read && !acc_q) begin
			rd_lo = idx == IDX_RES_LO;
			rd_hi = idx == IDX_RES_HI;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			acc_q <= 1'b0;
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
			avs_response <= 2'b00;
		end else if (clk_en) begin
			// acc_q marks the answer cycle; a held request is not
			// taken twice because acc_q blocks the second edge
			acc_q <= acc_start;
			avs_waitrequest <= !acc_start;
			if (acc_start) begin
				avs_readdata <= rd_d;
				avs_response <= resp_d;
			end
		end
	end

	// result byte presentation, decoded from the stored word on every
	// read so that a change of alignment shows at once, even mid
	// conversion
	always_comb begin
		if (cfg_q[C_LAR]) begin
			hi_b = result_q[9:2];
			lo_b = {result_q[1:0], 6'b00_0000};
		end else begin
			hi_b = {6'b00_0000, result_q[9:8]};
			lo_b = result_q[7:0];
		end
	end

	always_comb begin
		rd_d = 32'h0000_0000;
		resp_d = 2'b00;
		unique case (idx)
			IDX_RES_LO: rd_d[7:0] = lo_b;
			IDX_RES_HI: rd_d[7:0] = hi_b;
			IDX_CSR_A: rd_d[7:0] = csr_a_q;
			IDX_CSR_B: rd_d[7:0] = csr_b_q;
			IDX_CFG: rd_d[7:0] = cfg_q;
			IDX_SAMPLE: rd_d[7:0] = {6'b00_0000, state_q};
			default: resp_d = 2'b10;
		endcase
	end

	// prescaler, idle while converter off
	// the mask gives the number of system clocks per converter clock
	// half period minus one; codes 000 and 001 both toggle every clock
	always_comb begin
		unique case (csr_a_q[2:0])
			3'b000, 3'b001: div_mask = 8'h00;
			3'b010: div_mask = 8'h01;
			3'b011: div_mask = 8'h03;
			3'b100: div_mask = 8'h07;
			3'b101: div_mask = 8'h0f;
			3'b110: div_mask = 8'h1f;
			default: div_mask = 8'h3f;
		endcase
	end
	// one tick per converter clock period, on its falling half
	assign tick = cclk_q && ((pre_q & div_mask[6:0]) == div_mask[6:0]);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pre_q <= 7'h00;
			cclk_q <= 1'b0;
		end else if (clk_en) begin
			if (!csr_a_q[A_ON]) begin
				pre_q <= 7'h00;
				cclk_q <= 1'b0;
			end else if ((pre_q & div_mask[6:0]) == div_mask[6:0]) begin
				pre_q <= 7'h00;
				cclk_q <= !cclk_q;
			end else begin
				pre_q <= pre_q + 7'd1;
			end
		end
	end

	// synchronisers for off-domain inputs
	// the sample word is only taken at completion, long after it has
	// settled, so a plain two-stage copy of the bus is enough
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			trg_s1_q <= '0;
			trg_s2_q <= '0;
			smp_s1_q <= 10'h000;
			smp_s2_q <= 10'h000;
		end else if (clk_en) begin
			trg_s1_q <= trig_flags;
			trg_s2_q <= trg_s1_q;
			smp_s1_q <= sample_value;
			smp_s2_q <= smp_s1_q;
		end
	end

	// selected trigger level; code 0 follows done flag but never edges
	// the level is kept through a select change, so moving from a low
	// source to a high one looks like a rising edge
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			trig_sel_q <= 1'b0;
		else if (clk_en)
			trig_sel_q <= (csr_b_q[2:0] == TS_FREE) ? csr_a_q[A_DONE]
				: trg_s2_q[csr_b_q[2:0]];
	end
	// a select change to a high source yields an edge here when the previously selected level was low
	// free running code never edges from the flag
	assign trig_edge = csr_a_q[A_ATE] && csr_b_q[2:0] != TS_FREE
		&& trg_s2_q[csr_b_q[2:0]] && !trig_sel_q;

	// a start needs the converter on, either already or in this write
	assign go_wr = wr_a && wb[A_GO] && (wb[A_ON] || csr_a_q[A_ON]);
	assign complete = state_q == ST_CONV && tick && cyc_q == 5'd1;
	assign done_set = complete;

	// conversion sequencer
	// cyc_q counts converter clocks left; completion is the last tick
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_OFF;
			cyc_q <= 5'd0;
			init_done_q <= 1'b0;
		end else if (clk_en) begin
			unique case (state_q)
				ST_OFF: begin
					init_done_q <= 1'b0;
					// enable and start in one write: the first
					// conversion runs its long initialising length
					if (go_wr) begin
						state_q <= ST_CONV;
						cyc_q <= CONV_FIRST;
					end else if (wr_a && wb[A_ON]) begin
						state_q <= ST_IDLE;
					end
				end
				ST_IDLE: begin
					if (go_wr || (trig_edge && csr_a_q[A_ON])) begin
						state_q <= ST_CONV;
						cyc_q <= init_done_q ? CONV_NORMAL : CONV_FIRST;
					end
				end
				default: begin
					if (tick)
						cyc_q <= cyc_q - 5'd1;
					if (complete) begin
						init_done_q <= 1'b1;
						if (csr_a_q[A_ATE] && csr_b_q[2:0] == TS_FREE) begin
							cyc_q <= CONV_NORMAL;
						end else begin
							state_q <= ST_IDLE;
						end
					end
				end
			endcase
			if (wr_a && !wb[A_ON])
				state_q <= ST_OFF;
		end
	end

	// control register a
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			csr_a_q <= RESET_BYTE;
		end else if (clk_en) begin
			if (wr_a) begin
				csr_a_q[A_ON] <= wb[A_ON];
				csr_a_q[A_ATE] <= wb[A_ATE];
				csr_a_q[A_IE] <= wb[A_IE];
				csr_a_q[2:0] <= wb[2:0];
			end
			// go mirrors a running conversion; zero writes ignored
			csr_a_q[A_GO] <= (state_q == ST_CONV && !complete) || go_wr
				|| (state_q == ST_IDLE && trig_edge)
				|| (complete && csr_a_q[A_ATE]
				&& csr_b_q[2:0] == TS_FREE);
			if (wr_a && !wb[A_ON])
				csr_a_q[A_GO] <= 1'b0;
			// set wins over a clear in the same cycle
			if (done_set)
				csr_a_q[A_DONE] <= 1'b1;
			else if (irq_taken || (wr_a && wb[A_DONE]))
				csr_a_q[A_DONE] <= 1'b0;
		end
	end

	// control register b and config register
	// cfg_act_q is the copy the front end sees; it only moves between
	// conversions so a running one keeps its reference and channel
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			csr_b_q <= RESET_BYTE;
			cfg_q <= RESET_BYTE;
			cfg_act_q <= RESET_BYTE;
		end else if (clk_en) begin
			if (wr_b)
				csr_b_q <= wb & B_WMASK;
			if (wr_c)
				cfg_q <= wb;
			if (state_q != ST_CONV || complete)
				cfg_act_q <= wr_c ? wb : cfg_q;
		end
	end

	// result register with read lock
	// while locked a finished conversion still sets the done flag but
	// its value is dropped; software must read the high byte to unlock
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			result_q <= 10'h000;
			lock_q <= 1'b0;
		end else if (clk_en) begin
			if (rd_lo)
				lock_q <= 1'b1;
			else if (rd_hi)
				lock_q <= 1'b0;
			// front end delivers the coded value
			if (complete && !lock_q)
				result_q <= smp_s2_q;
		end
	end

	// outputs
	// every port is registered, so each follows its source one clock
	// late; done_irq in particular lags the flag by one cycle
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			done_irq <= 1'b0;
			conv_clk <= 1'b0;
			conv_power <= 1'b0;
			conv_sample <= 1'b0;
			ref_select <= 2'b00;
			channel_select <= 5'h00;
			bipolar_mode <= 1'b0;
		end else if (clk_en) begin
			done_irq <= csr_a_q[A_DONE] && csr_a_q[A_IE]
				&& global_irq_enable;
			conv_clk <= cclk_q;
			conv_power <= csr_a_q[A_ON];
			conv_sample <= state_q == ST_CONV;
			ref_select <= cfg_act_q[7:6];
			channel_select <= cfg_act_q[4:0];
			bipolar_mode <= csr_b_q[B_BIP];
		end
	end
endmodule

`default_nettype wire

// ==== rtl/adc_ctl_pkg.sv ====
// constants for the converter control and status block
// assumes a 32-bit avalon-mm slave with word addressing by byte address
package adc_ctl_pkg;
	// register word indices (printed offsets are not multiples of four:
	// each printed offset is an index, byte address is four times it)
	localparam logic [7:0] IDX_RES_LO = 8'h78;
	localparam logic [7:0] IDX_RES_HI = 8'h79;
	localparam logic [7:0] IDX_CSR_A = 8'h7a;
	localparam logic [7:0] IDX_CSR_B = 8'h7b;
	localparam logic [7:0] IDX_CFG = 8'h7c;
	localparam logic [7:0] IDX_SAMPLE = 8'h7d;
	localparam int ADDR_W = 10;
	// csr_a fields
	localparam int A_ON = 7;
	localparam int A_GO = 6;
	localparam int A_ATE = 5;
	localparam int A_DONE = 4;
	localparam int A_IE = 3;
	// csr_b fields
	localparam int B_BIP = 7;
	localparam int B_RSV = 3;
	localparam logic [7:0] B_WMASK = 8'hf7;
	// cfg register: left_align bit 5, ref select 7:6, channel 4:0
	localparam int C_LAR = 5;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	// conversion lengths in converter clock cycles
	localparam logic [4:0] CONV_FIRST = 5'd25;
	localparam logic [4:0] CONV_NORMAL = 5'd13;
	// trigger select code that means free running
	localparam logic [2:0] TS_FREE = 3'h0;
	// trigger codes: 1 comparator, 2 ext int 0, 3 t1 cmp a,
	// 4 t1 ovf, 5 t1 cmp b, 6 t1 capture, 7 watchdog
	localparam int N_TRIG = 8;
	typedef enum logic [1:0] {
		ST_OFF = 2'b00,
		ST_IDLE = 2'b01,
		ST_CONV = 2'b10
	} conv_state_t;
endpackage

// ==== dv/adc_ctl_monitor.sv ====
// concurrent checks on the converter control block ports
// assumes the bus master holds each request until waitrequest is low
`timescale 1ns/1ps
`default_nettype none
module adc_ctl_monitor
	import adc_ctl_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// register bus
	input wire logic [adc_ctl_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic avs_waitrequest,
	input wire logic [1:0] avs_response,
	// interrupt and front end
	input wire logic global_irq_enable,
	input wire logic irq_taken,
	input wire logic done_irq,
	input wire logic conv_clk,
	input wire logic conv_power,
	input wire logic conv_sample,
	input wire logic bipolar_mode
);
	logic req;
	logic wr_ok;
	logic wr_a;
	logic wr_b;
	assign req = avs_read | avs_write;
	assign wr_ok = avs_write & !avs_waitrequest & avs_byteenable[0];
	assign wr_a = wr_ok & (avs_address == {IDX_CSR_A, 2'b00});
	assign wr_b = wr_ok & (avs_address == {IDX_CSR_B, 2'b00});
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	a_wait_answer: assert property (req && avs_waitrequest |=> !avs_waitrequest)
		else $error("no answer one cycle after a request");
	a_wait_idle: assert property (!req |=> avs_waitrequest)
		else $error("waitrequest low without a request");
	a_unmapped_err: assert property (avs_read && avs_waitrequest &&
		avs_address == 10'h3fc |=> avs_response == 2'b10)
		else $error("unmapped read not refused");
	a_off_power: assert property (wr_a && !avs_writedata[7] |=> ##[0:1] !conv_power)
		else $error("converter still powered after switch off");
	a_off_abort: assert property (wr_a && !avs_writedata[7] |=> ##[0:2] !conv_sample)
		else $error("conversion not aborted on switch off");
	a_irq_global: assert property (!global_irq_enable |=> !done_irq)
		else $error("interrupt without global enable");
	a_irq_taken: assert property (irq_taken && !conv_sample |=> ##1 !done_irq)
		else $error("interrupt stays after vector taken");
	a_bip_follow: assert property (wr_b && avs_writedata[7] |=> ##[0:1] bipolar_mode)
		else $error("bipolar mode not passed on");
	a_clk_idle: assert property (!conv_power [*3] |=> $stable(conv_clk))
		else $error("converter clock runs while off");
endmodule
bind adc_ctl adc_ctl_monitor i_adc_ctl_monitor (.clk_sys, .rst_n, .avs_address,
	.avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest,
	.avs_response, .global_irq_enable, .irq_taken, .done_irq, .conv_clk,
	.conv_power, .conv_sample, .bipolar_mode);
`default_nettype wire

// ==== dv/tb_top.sv ====
// self-checking bench for the converter control block via its registers
// assumes one design instance and a 250 MHz system clock
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import adc_ctl_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic [9:0] avs_address = 10'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [1:0] avs_response;
	logic global_irq_enable = 1'b0;
	logic irq_taken = 1'b0;
	logic done_irq;
	logic [7:0] trig_flags = 8'h0;
	logic [9:0] sample_value = 10'h2a5;
	logic conv_clk;
	logic conv_power;
	logic conv_sample;
	logic [7:0] rd;
	int error_cnt = 0;
	int num_checks = 0;
	int n;
	always #2 clk_sys = ~clk_sys;
	adc_ctl i_adc_ctl (.clk_sys, .rst_n, .clk_en(1'b1), .avs_address,
		.avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'h1),
		.avs_readdata, .avs_waitrequest, .avs_response, .global_irq_enable,
		.irq_taken, .done_irq, .trig_flags, .sample_value, .conv_clk,
		.conv_power, .conv_sample, .ref_select(), .channel_select(),
		.bipolar_mode());
	task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
		@(posedge clk_sys);
		avs_address <= {idx, 2'b00};
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= {24'h0, d};
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
		rd = avs_readdata[7:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rg(input logic [7:0] idx, input logic [7:0] exp);
		bus(1'b0, idx, 8'h0);
		chk(rd, exp);
	endtask
	// waits for a conversion to start, returns its length in clocks
	task automatic conv_len(output int len);
		int k;
		k = 0;
		len = 0;
		while (conv_sample !== 1'b1 && k < 400) begin
			@(posedge clk_sys);
			k++;
		end
		while (conv_sample === 1'b1 && len < 4000) begin
			@(posedge clk_sys);
			len++;
		end
	endtask
	task automatic t_reset;
		rg(IDX_CSR_A, 8'h00);
		rg(IDX_RES_LO, 8'h00);
		rg(IDX_RES_HI, 8'h00);
		bus(1'b1, IDX_CSR_B, 8'hff);
		rg(IDX_CSR_B, 8'hf7);
		bus(1'b1, IDX_CSR_B, 8'h00);
		rg(8'hff, 8'h00);
		chk({6'h0, avs_response}, 8'h02);
	endtask
	task automatic t_conv;
		bus(1'b1, IDX_CSR_A, 8'hc0);
		conv_len(n);
		chk({7'h0, n inside {[49:51]}}, 8'h01);
		rg(IDX_CSR_A, 8'h90);
		bus(1'b1, IDX_CSR_A, 8'hd0);
		conv_len(n);
		chk({7'h0, n inside {[25:27]}}, 8'h01);
		rg(IDX_CSR_A, 8'h90);
		rg(IDX_RES_LO, 8'ha5);
		rg(IDX_RES_HI, 8'h02);
		bus(1'b1, IDX_CFG, 8'h20);
		rg(IDX_RES_HI, 8'ha9);
		rg(IDX_RES_LO, 8'h40);
		bus(1'b1, IDX_CFG, 8'h00);
		sample_value <= 10'h155;
		bus(1'b1, IDX_CSR_A, 8'hd0);
		conv_len(n);
		rg(IDX_RES_HI, 8'h02);
		bus(1'b1, IDX_CSR_A, 8'hd0);
		conv_len(n);
		rg(IDX_RES_LO, 8'h55);
		rg(IDX_RES_HI, 8'h01);
	endtask
	task automatic t_irq;
		bus(1'b1, IDX_CSR_A, 8'h88);
		global_irq_enable <= 1'b1;
		repeat (3) @(posedge clk_sys);
		chk({7'h0, done_irq}, 8'h01);
		irq_taken <= 1'b1;
		@(posedge clk_sys);
		irq_taken <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk({7'h0, done_irq}, 8'h00);
		rg(IDX_CSR_A, 8'h88);
	endtask
	task automatic t_trig;
		bus(1'b1, IDX_CSR_B, 8'h02);
		bus(1'b1, IDX_CSR_A, 8'hb0);
		trig_flags <= 8'h04;
		conv_len(n);
		chk({7'h0, n inside {[25:27]}}, 8'h01);
		trig_flags <= 8'h02;
		bus(1'b1, IDX_CSR_B, 8'h81);
		conv_len(n);
		chk({7'h0, n > 0}, 8'h01);
		bus(1'b1, IDX_CSR_B, 8'h00);
		repeat (20) @(posedge clk_sys);
		chk({7'h0, conv_sample}, 8'h00);
	endtask
	task automatic t_free;
		bus(1'b1, IDX_CSR_A, 8'hf0);
		repeat (100) @(posedge clk_sys);
		bus(1'b1, IDX_CSR_A, 8'hb0);
		repeat (40) @(posedge clk_sys);
		bus(1'b0, IDX_CSR_A, 8'h00);
		chk(rd, 8'hf0);
		bus(1'b1, IDX_CSR_A, 8'h00);
		rg(IDX_CSR_A, 8'h10);
		chk({7'h0, conv_power}, 8'h00);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_reset();
		t_conv();
		t_irq();
		t_trig();
		t_free();
		tally_and_finish();
	end
	initial begin
		#200000;
		error_cnt++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
